/* shared/lpi_pkg.sv */
`default_nettype none
package lpi_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_PROG_FORMAT = 8'h1d;
   localparam logic [7:0] ADDR_ACT_FORMAT = 8'h23;
   localparam logic [7:0] ADDR_LATCHED_FORMAT = 8'h26;
   localparam logic [7:0] ADDR_PRODUCT_CODE = 8'hfd;
   localparam logic [7:0] ADDR_MAKER_CODE = 8'hfe;
   localparam logic [7:0] ADDR_DIE_REVISION = 8'hff;
   // reset values
   localparam logic [7:0] FORMAT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // field positions
   localparam int SENSE_FIELD_LSB = 4;
   localparam int BUS_FIELD_LSB = 0;
   localparam int CHANNELS = 4;
   // ==========================================================
   // timing: results valid after an update command
   localparam int VALID_DELAY_US = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int VALID_DELAY_CYCLES = (VALID_DELAY_US * 1000) / CLK_PERIOD_NS;
   // ==========================================================
   // update command variants
   typedef enum logic [1:0] {
      UPD_NONE,
      UPD_PLAIN,
      UPD_VOLTAGE,
      UPD_GLOBAL
   } lpi_update_t;
   // host register access
   typedef struct packed {
      logic rdEn;
      logic wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } lpi_reg_req_t;
endpackage : lpi_pkg
`default_nettype wire

/* verilog/lpi_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - latch active format before each update
// - latched image valid one millisecond later
// - programmed format inert until update
// - all update variants capture alike
// - bits 7-4 sense bipolar per channel
// - bits 3-0 bus bipolar per channel
// - fixed read-only product code register
// - fixed read-only maker code register
// - fixed read-only die revision register
// - active format loaded from programmed on update
module lpi_regs #(
   parameter int VALID_CYCLES = lpi_pkg::VALID_DELAY_CYCLES,
   parameter logic [7:0] PRODUCT_CODE = 8'ha1, // arbitrary value
   parameter logic [7:0] MAKER_CODE = 8'hb2, // arbitrary value
   parameter logic [7:0] DIE_REVISION = 8'hc3 // arbitrary value
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire lpi_pkg::lpi_reg_req_t regReq,
   input wire lpi_pkg::lpi_update_t updateCmd,
   output logic [7:0] rdData,
   output logic [7:0] activeFormat,
   output logic latchedValid
);
   import lpi_pkg::*;

   localparam int CW = $clog2(VALID_CYCLES + 1);

   logic [7:0] progFormat_q, progFormat_d;
   logic [7:0] actFormat_q, actFormat_d;
   logic [7:0] latFormat_q, latFormat_d;
   logic [CW-1:0] validCnt_q, validCnt_d;
   logic valid_q, valid_d;
   logic [7:0] rdData_q, rdData_d;
   logic updateHit;

   // ==========================================================
   // format settings
   // any variant counts as an update
   assign updateHit = (updateCmd != UPD_NONE);

   // next values of the three format registers
   always_comb begin
      progFormat_d = progFormat_q;
      actFormat_d = actFormat_q;
      latFormat_d = latFormat_q;
      if (regReq.wrEn && regReq.addr == ADDR_PROG_FORMAT) begin
         progFormat_d = regReq.wrData;
      end
      if (updateHit) begin
         latFormat_d = actFormat_q;
         actFormat_d = progFormat_q;
      end
   end

   // register format state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         progFormat_q <= FORMAT_RESET;
         actFormat_q <= FORMAT_RESET;
         latFormat_q <= FORMAT_RESET;
      end else if (clkEn) begin
         progFormat_q <= progFormat_d;
         actFormat_q <= actFormat_d;
         latFormat_q <= latFormat_d;
      end
   end

   // ==========================================================
   // validity timer
   // restart on each update, valid when count expires
   always_comb begin
      validCnt_d = validCnt_q;
      valid_d = valid_q;
      if (updateHit) begin
         validCnt_d = CW'(VALID_CYCLES - 1);
         valid_d = 1'b0;
      end else if (!valid_q) begin
         if (validCnt_q == '0) begin
            valid_d = 1'b1;
         end else begin
            validCnt_d = validCnt_q - 1'b1;
         end
      end
   end

   // register timer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         validCnt_q <= '0;
         valid_q <= 1'b1;
      end else if (clkEn) begin
         validCnt_q <= validCnt_d;
         valid_q <= valid_d;
      end
   end

   // ==========================================================
   // read path, writes to read-only offsets fall through
   always_comb begin
      rdData_d = rdData_q;
      if (regReq.rdEn) begin
         case (regReq.addr)
            ADDR_PROG_FORMAT: rdData_d = progFormat_q;
            ADDR_ACT_FORMAT: rdData_d = actFormat_q;
            ADDR_LATCHED_FORMAT: rdData_d = latFormat_q;
            ADDR_PRODUCT_CODE: rdData_d = PRODUCT_CODE;
            ADDR_MAKER_CODE: rdData_d = MAKER_CODE;
            ADDR_DIE_REVISION: rdData_d = DIE_REVISION;
            default: rdData_d = UNMAPPED_READ; // unmapped offsets read zero
         endcase
      end
   end

   // register read data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_q <= UNMAPPED_READ;
      end else if (clkEn) begin
         rdData_q <= rdData_d;
      end
   end

   assign rdData = rdData_q;
   assign activeFormat = actFormat_q;
   assign latchedValid = valid_q;

   // ==========================================================
   // checks
   // enabled edges since the last update, saturating at the valid delay
   logic [CW-1:0] chkAge_q, chkAge_d;

   // next age, counted apart from the valid timer
   always_comb begin
      chkAge_d = chkAge_q;
      if (updateHit) begin
         chkAge_d = '0;
      end else if (chkAge_q < CW'(VALID_CYCLES)) begin
         chkAge_d = chkAge_q + 1'b1;
      end
   end

   // register age, frozen like the rest of the state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chkAge_q <= CW'(VALID_CYCLES);
      end else if (clkEn) begin
         chkAge_q <= chkAge_d;
      end
   end

   // an update is only taken on an enabled edge
   sequence s_update;
      clkEn && updateHit;
   endsequence

   // capture and activation on every update
   a_latch_capture: assert property (@(posedge sys_clk) disable iff (rst)
      s_update |=> latFormat_q == $past(actFormat_q))
      else $error("latched image not captured from active");
   a_active_load: assert property (@(posedge sys_clk) disable iff (rst)
      s_update |=> actFormat_q == $past(progFormat_q))
      else $error("active format not loaded");
   a_variant_same: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && updateCmd inside {UPD_VOLTAGE, UPD_GLOBAL} |=> latFormat_q == $past(actFormat_q))
      else $error("update variant did not capture");
   a_sense_field: assert property (@(posedge sys_clk) disable iff (rst)
      s_update |=> latFormat_q[SENSE_FIELD_LSB +: CHANNELS]
         == $past(actFormat_q[SENSE_FIELD_LSB +: CHANNELS]))
      else $error("sense format field not captured");
   a_bus_field: assert property (@(posedge sys_clk) disable iff (rst)
      s_update |=> latFormat_q[BUS_FIELD_LSB +: CHANNELS]
         == $past(actFormat_q[BUS_FIELD_LSB +: CHANNELS]))
      else $error("bus format field not captured");

   // active and latched formats hold without an update, nothing moves while frozen
   a_active_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !updateHit && clkEn |=> $stable(actFormat_q))
      else $error("active format changed without update");
   a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !updateHit |=> $stable(latFormat_q))
      else $error("latched image changed without update");
   a_state_freeze: assert property (@(posedge sys_clk) disable iff (rst)
      !clkEn |=> $stable(progFormat_q) && $stable(actFormat_q) && $stable(latFormat_q)
         && $stable(rdData_q) && $stable(valid_q) && $stable(validCnt_q))
      else $error("state moved while clock enable low");

   // only the programmable offset takes writes
   a_prog_write: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.wrEn && regReq.addr == ADDR_PROG_FORMAT
      |=> progFormat_q == $past(regReq.wrData))
      else $error("programmed format write lost");
   a_ro_write: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.wrEn && regReq.addr != ADDR_PROG_FORMAT
      |=> $stable(progFormat_q))
      else $error("write to other offset changed programmed format");
   a_latch_ro: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.wrEn && regReq.addr == ADDR_LATCHED_FORMAT && !updateHit
      |=> $stable(latFormat_q))
      else $error("write reached latched image");

   // valid drops on update and returns exactly one delay later
   a_valid_drop: assert property (@(posedge sys_clk) disable iff (rst)
      s_update |=> !latchedValid)
      else $error("valid not cleared on update");
   a_valid_early: assert property (@(posedge sys_clk) disable iff (rst)
      chkAge_q < CW'(VALID_CYCLES) |-> !latchedValid)
      else $error("latched image valid too early");
   a_valid_late: assert property (@(posedge sys_clk) disable iff (rst)
      chkAge_q == CW'(VALID_CYCLES) |-> latchedValid)
      else $error("latched image valid too late");

   // read-back of fixed codes and latched image
   a_product_read: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.rdEn && regReq.addr == ADDR_PRODUCT_CODE
      |=> rdData == PRODUCT_CODE)
      else $error("product code mismatch");
   a_maker_read: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.rdEn && regReq.addr == ADDR_MAKER_CODE
      |=> rdData == MAKER_CODE)
      else $error("maker code mismatch");
   a_revision_read: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.rdEn && regReq.addr == ADDR_DIE_REVISION
      |=> rdData == DIE_REVISION)
      else $error("revision code mismatch");
   a_latch_read: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && regReq.rdEn && regReq.addr == ADDR_LATCHED_FORMAT && !updateHit
      |=> rdData == latFormat_q)
      else $error("latched image read mismatch");
endmodule : lpi_regs
`default_nettype wire

/* bench/lpi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side of the register and update ports
module lpi_host_model
   import lpi_pkg::*;
(
   input wire logic sys_clk,
   output lpi_pkg::lpi_reg_req_t regReq,
   output lpi_pkg::lpi_update_t updateCmd
);
   // idle at time zero
   initial begin
      regReq = '0;
      updateCmd = UPD_NONE;
   end
   // one access, held until its sampling edge
   task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
      regReq <= '{rdEn: rd, wrEn: !rd, addr: a, wrData: d};
      @(posedge sys_clk);
      regReq <= '0;
   endtask : acc
   // one-cycle update pulse
   task automatic upd(input lpi_update_t c);
      updateCmd <= c;
      @(posedge sys_clk);
      updateCmd <= UPD_NONE;
   endtask : upd
endmodule : lpi_host_model
`default_nettype wire

/* bench/tb_lpi_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module tb_lpi_regs;
   import lpi_pkg::*;
   localparam int VC = 8;
   logic sys_clk = 0;
   logic rst = 1;
   logic clkEn = 1;
   lpi_reg_req_t regReq;
   lpi_update_t updateCmd;
   logic [7:0] rdData;
   logic [7:0] activeFormat;
   logic latchedValid;
   logic [7:0] prev;
   int n_fail = 0;
   int compares = 0;
   int n;
   logic [7:0] ra[4] = '{ADDR_LATCHED_FORMAT, ADDR_PRODUCT_CODE, ADDR_MAKER_CODE,
      ADDR_DIE_REVISION};
   logic [7:0] re[4] = '{8'h00, 8'h4e, 8'h6b, 8'h17}; // latched format reset value, then arbitrary id values
   logic [7:0] vs[3] = '{8'h81, 8'h42, 8'h3c};
   lpi_update_t cs[3] = '{UPD_PLAIN, UPD_VOLTAGE, UPD_GLOBAL};
   lpi_regs #(.VALID_CYCLES(VC), .PRODUCT_CODE(8'h4e), .MAKER_CODE(8'h6b),
      .DIE_REVISION(8'h17)) dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
      .regReq(regReq), .updateCmd(updateCmd), .rdData(rdData),
      .activeFormat(activeFormat), .latchedValid(latchedValid));
   lpi_host_model host (.sys_clk(sys_clk), .regReq(regReq), .updateCmd(updateCmd));
   // clock
   initial forever #5 sys_clk = ~sys_clk;
   // ==========
   // access tasks
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
      host.acc(1'b1, a, 8'h00);
      #1;
      `CHK(s, e, rdData)
      @(posedge sys_clk);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.acc(1'b0, a, d);
      @(posedge sys_clk);
   endtask : wr
   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // ==========
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK("valid", 1'b1, latchedValid)
      @(posedge sys_clk);
      prev = FORMAT_RESET;
      // read-only places refuse writes
      for (int i = 0; i < 4; i++) begin
         wr(ra[i], 8'h5a);
         rd(ra[i], re[i], "ro");
      end
      rd(8'h50, UNMAPPED_READ, "unmapped");
      // every update variant
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_PROG_FORMAT, vs[i]);
         rd(ADDR_ACT_FORMAT, prev, "active before");
         host.upd(cs[i]);
         n = 0;
         #1;
         while (latchedValid !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
            #1;
         end
         `CHK("settle", VC, n)
         if (n == 50) begin
            n_fail++;
            wrap_up();
         end
         @(posedge sys_clk);
         rd(ADDR_LATCHED_FORMAT, prev, "latched");
         rd(ADDR_ACT_FORMAT, vs[i], "active after");
         `CHK("port", vs[i], activeFormat)
         prev = vs[i];
      end
      // frozen clock enable ignores write and update
      clkEn <= 1'b0;
      wr(ADDR_PROG_FORMAT, 8'h99);
      host.upd(UPD_PLAIN);
      #1;
      `CHK("frozen active", vs[2], activeFormat)
      `CHK("frozen valid", 1'b1, latchedValid)
      @(posedge sys_clk);
      clkEn <= 1'b1;
      rd(ADDR_PROG_FORMAT, vs[2], "frozen prog");
      rd(ADDR_LATCHED_FORMAT, vs[1], "frozen latched");
      // reset in mid-run restores every format register
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      `CHK("reset active", FORMAT_RESET, activeFormat)
      `CHK("reset valid", 1'b1, latchedValid)
      @(posedge sys_clk);
      rd(ADDR_LATCHED_FORMAT, FORMAT_RESET, "reset latched");
      rd(ADDR_PROG_FORMAT, FORMAT_RESET, "reset prog");
      wrap_up();
   end
endmodule : tb_lpi_regs
`default_nettype wire
